// ===== rtl/afx_host.sv
`timescale 1ns/1ns
`include "afx_regs.svh"
module afx_host
    import afx_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [1:0]  api_framing_select,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_frame_id,
    input  wire logic [63:0] req_dest,
    input  wire logic        req_broadcast,
    input  wire logic [7:0]  req_options,
    input  wire logic [15:0] req_pay_len,
    input  wire logic        pay_valid,
    output logic             pay_ready,
    input  wire logic [7:0]  pay_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             stat_valid,
    output logic [7:0]       stat_frame_id,
    output logic [7:0]       stat_delivery,
    output logic             stat_error
);
    ////////////////////////////////////////////////////////////////////
    afx_tx_state_t ts_q;
    logic [3:0]    idx_q;
    logic [15:0]   len_q;
    logic [15:0]   pay_cnt_q;
    logic [7:0]    fid_q;
    logic [63:0]   dest_sh_q;
    logic [7:0]    opt_q;
    logic [7:0]    sum_q;
    logic          esc_pend_q;
    logic [7:0]    fifo_data;
    logic [7:0]    raw;
    logic          fifo_valid, fifo_pop, have, need_esc;
    logic          load, adv, summed, take;
    afx_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (pay_valid),
        .in_ready  (pay_ready),
        .in_data   (pay_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Raw byte at the current frame position
    always_comb begin
        raw  = 8'h00;
        have = 1'b0;
        case (ts_q)
            TS_HDR: begin
                have = 1'b1;
                case (idx_q)
                    `AFX_OFS_DELIM:  raw = `AFX_DELIM;
                    `AFX_OFS_LEN_HI: raw = len_q[15:8];
                    `AFX_OFS_LEN_LO: raw = len_q[7:0];
                    `AFX_OFS_TYPE:   raw = `AFX_TYPE_TX64;
                    `AFX_OFS_FID:    raw = fid_q;
                    `AFX_OFS_OPT:    raw = opt_q;
                    default:         raw = dest_sh_q[63:56];
                endcase
            end
            TS_PAY, TS_RAW: begin
                have = fifo_valid;
                raw  = fifo_data;
            end
            TS_SUM: begin
                have = 1'b1;
                raw  = `AFX_CSUM_BASE - sum_q;
            end
            default: have = 1'b0;
        endcase
    end
    // Delimiter at offset 0 and transparent bytes are never escaped
    assign need_esc = (api_framing_select == `AFX_MODE_ESCAPED)
                   && (ts_q != TS_RAW)
                   && !(ts_q == TS_HDR && idx_q == `AFX_OFS_DELIM)
                   && (raw == `AFX_DELIM || raw == `AFX_ESC
                    || raw == `AFX_XON || raw == `AFX_XOFF);
    assign load     = !tx_valid || tx_ready;
    assign adv      = load && have && (esc_pend_q || !need_esc);
    assign fifo_pop = adv && (ts_q == TS_PAY || ts_q == TS_RAW);
    assign take     = req_valid && req_ready;
    assign summed   = (ts_q == TS_PAY)
                   || (ts_q == TS_HDR && idx_q >= `AFX_OFS_TYPE);

    ////////////////////////////////////////////////////////////////////
    // Output byte register, escape prefix first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_valid   <= 1'b0;
            tx_data    <= 8'h00;
            esc_pend_q <= 1'b0;
        end else if (load) begin
            tx_valid <= have;
            if (have && esc_pend_q) begin
                tx_data    <= raw ^ `AFX_ESC_XOR;
                esc_pend_q <= 1'b0;
            end else if (have && need_esc) begin
                tx_data    <= `AFX_ESC;
                esc_pend_q <= 1'b1;
            end else if (have) begin
                tx_data <= raw;
            end
        end
    end
    // Sum on raw bytes only, so escapes never count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sum_q <= 8'h00;
        end else if (take) begin
            sum_q <= 8'h00;
        end else if (adv && summed) begin
            sum_q <= sum_q + raw;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            len_q     <= 16'h0000;
            pay_cnt_q <= 16'h0000;
            fid_q     <= 8'h00;
            dest_sh_q <= 64'h0;
            opt_q     <= 8'h00;
        end else if (take) begin
            len_q     <= `AFX_HDR_DATA_LEN + req_pay_len;
            pay_cnt_q <= req_pay_len;
            fid_q     <= req_frame_id;
            dest_sh_q <= req_broadcast ? `AFX_BCAST_ADDR : req_dest;
            opt_q     <= req_options & `AFX_OPT_LEGAL;
        end else if (adv) begin
            if (ts_q == TS_HDR && idx_q >= `AFX_OFS_DEST
                && idx_q < `AFX_OFS_OPT) begin
                dest_sh_q <= {dest_sh_q[55:0], 8'h00};
            end
            if (ts_q == TS_PAY) begin
                pay_cnt_q <= pay_cnt_q - 16'h0001;
            end
        end
    end
    // Request taken only from idle; ready lags idle by one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ts_q      <= TS_IDLE;
            idx_q     <= 4'h0;
            req_ready <= 1'b0;
        end else begin
            req_ready <= 1'b0;
            case (ts_q)
                TS_IDLE: begin
                    idx_q <= 4'h0;
                    if (api_framing_select == `AFX_MODE_TRANSP) begin
                        ts_q <= TS_RAW;
                    end else if (take) begin
                        ts_q <= TS_HDR;
                    end else begin
                        req_ready <= 1'b1;
                    end
                end
                TS_RAW: begin
                    if (api_framing_select != `AFX_MODE_TRANSP) begin
                        ts_q <= TS_IDLE;
                    end
                end
                TS_HDR: begin
                    if (adv) begin
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == `AFX_OFS_OPT) begin
                            ts_q <= (pay_cnt_q == 16'h0000) ? TS_SUM
                                                            : TS_PAY;
                        end
                    end
                end
                TS_PAY: begin
                    if (adv && pay_cnt_q == 16'h0001) begin
                        ts_q <= TS_SUM;
                    end
                end
                TS_SUM: begin
                    if (adv) begin
                        ts_q <= TS_IDLE;
                    end
                end
                default: ts_q <= TS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status frame receiver
    afx_rx_state_t rs_q;
    logic          rx_esc_q;
    logic [15:0]   rx_len_q;
    logic [15:0]   rx_cnt_q;
    logic [7:0]    rx_sum_q;
    logic [7:0]    rx_type_q;
    logic [7:0]    rx_fid_q;
    logic [7:0]    rx_stat_q;
    logic          restart, esc_in, byte_ok;
    logic [7:0]    val;
    // Framed-plain mode can carry 0x7e as data, so resync only when idle
    assign restart = rx_valid && rx_data == `AFX_DELIM
                  && api_framing_select != `AFX_MODE_TRANSP
                  && (api_framing_select == `AFX_MODE_ESCAPED
                   || rs_q == RS_WAIT);
    assign esc_in  = rx_valid && !rx_esc_q && rx_data == `AFX_ESC
                  && api_framing_select == `AFX_MODE_ESCAPED;
    assign byte_ok = rx_valid && !restart && !esc_in;
    assign val     = rx_esc_q ? (rx_data ^ `AFX_ESC_XOR) : rx_data;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_esc_q <= 1'b0;
        end else if (rx_valid) begin
            rx_esc_q <= esc_in;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rs_q       <= RS_WAIT;
            rx_len_q   <= 16'h0000;
            rx_cnt_q   <= 16'h0000;
            rx_sum_q   <= 8'h00;
            rx_type_q  <= 8'h00;
            rx_fid_q   <= 8'h00;
            rx_stat_q  <= 8'h00;
        end else if (restart) begin
            rs_q     <= RS_LEN_HI;
            rx_cnt_q <= 16'h0000;
            rx_sum_q <= 8'h00;
        end else if (byte_ok) begin
            case (rs_q)
                RS_LEN_HI: begin
                    rx_len_q[15:8] <= val;
                    rs_q           <= RS_LEN_LO;
                end
                RS_LEN_LO: begin
                    rx_len_q[7:0] <= val;
                    rs_q <= ({rx_len_q[15:8], val} == 16'h0000) ? RS_SUM
                                                                : RS_BODY;
                end
                RS_BODY: begin
                    rx_sum_q <= rx_sum_q + val;
                    rx_cnt_q <= rx_cnt_q + 16'h0001;
                    case (rx_cnt_q)
                        16'h0000: rx_type_q <= val;
                        16'h0001: rx_fid_q  <= val;
                        16'h0002: rx_stat_q <= val;
                        default:  rx_stat_q <= rx_stat_q;
                    endcase
                    if (rx_cnt_q + 16'h0001 == rx_len_q) begin
                        rs_q <= RS_SUM;
                    end
                end
                default: rs_q <= RS_WAIT;
            endcase
        end
    end
    // Only a whole, checked status frame reaches the user
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stat_valid    <= 1'b0;
            stat_error    <= 1'b0;
            stat_frame_id <= 8'h00;
            stat_delivery <= 8'h00;
        end else begin
            stat_valid <= 1'b0;
            stat_error <= 1'b0;
            if (byte_ok && rs_q == RS_SUM) begin
                if (rx_sum_q + val == `AFX_CSUM_BASE
                    && rx_type_q == `AFX_TYPE_STATUS
                    && rx_len_q >= `AFX_STAT_MIN_LEN) begin
                    stat_valid    <= 1'b1;
                    stat_frame_id <= rx_fid_q;
                    stat_delivery <= rx_stat_q;
                end else begin
                    stat_error <= 1'b1;
                end
            end
        end
    end
endmodule : afx_host

// ===== rtl/afx_regs.svh
`ifndef AFX_REGS_SVH
`define AFX_REGS_SVH
// Notes on behaviour
// - Escaped mode sends 0x7D then byte XOR 0x20; receiver XORs next byte.
// - Escape exactly 0x7E, 0x7D, 0x11 and 0x13.
// - Length counts unescaped bytes only, never inserted escapes.
// - Checksum covers unescaped contents; escape bytes never summed.
// - Each frame opens at offset 0 with delimiter 0x7E.
// - 16-bit length at offset 1 counts bytes between length and checksum.
// - Type byte at offset 3; 0x00 means 64-bit addressed transmit request.
// - 64-bit destination address starts at offset 5.
// - Host may combine options but drives unused bits zero.
// - Payload from offset 14 to byte before checksum, variable length.
// - Checksum is 0xFF minus low byte of sum from offset 3 on.
// - Mode 0 transparent, 1 framed, 2 framed with escaping.
// - Length sent most significant byte first.
`define AFX_DELIM        8'h7e
`define AFX_ESC          8'h7d
`define AFX_ESC_XOR      8'h20
`define AFX_XON          8'h11
`define AFX_XOFF         8'h13
`define AFX_TYPE_TX64    8'h00
`define AFX_TYPE_STATUS  8'h89
`define AFX_CSUM_BASE    8'hff
`define AFX_OFS_DELIM    4'h0
`define AFX_OFS_LEN_HI   4'h1
`define AFX_OFS_LEN_LO   4'h2
`define AFX_OFS_TYPE     4'h3
`define AFX_OFS_FID      4'h4
`define AFX_OFS_DEST     4'h5
`define AFX_OFS_OPT      4'hd
`define AFX_OPT_LEGAL    8'h05
`define AFX_BCAST_ADDR   64'h0000_0000_0000_ffff
`define AFX_HDR_DATA_LEN 16'h000b
`define AFX_MODE_TRANSP  2'h0
`define AFX_MODE_FRAMED  2'h1
`define AFX_MODE_ESCAPED 2'h2
`define AFX_STAT_MIN_LEN 16'h0003
`endif

// ===== rtl/afx_pkg.sv
package afx_pkg;
    typedef enum logic [2:0] {
        TS_IDLE = 3'h0,
        TS_HDR  = 3'h1,
        TS_PAY  = 3'h3,
        TS_SUM  = 3'h2,
        TS_RAW  = 3'h6
    } afx_tx_state_t;
    typedef enum logic [2:0] {
        RS_WAIT   = 3'h0,
        RS_LEN_HI = 3'h1,
        RS_LEN_LO = 3'h3,
        RS_BODY   = 3'h2,
        RS_SUM    = 3'h6
    } afx_rx_state_t;
endpackage : afx_pkg

// ===== rtl/afx_fifo.sv
`timescale 1ns/1ns
module afx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign out_valid = (count_q != '0);
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            in_ready <= 1'b0;
        end else begin
            // Registered ready so the top's pay_ready is a flop output
            count_q  <= count_d;
            in_ready <= (count_d != (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end
endmodule : afx_fifo

// ===== tb/afx_host_assertions.sv
`timescale 1ns/1ns
module afx_host_assertions (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [1:0] api_framing_select,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       rx_valid,
    input wire logic       stat_valid,
    input wire logic       stat_error
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    a_frame_start: assert property (
        req_valid && req_ready |-> ##[1:3] tx_valid && tx_data == 8'h7e)
        else $error("delimiter late");
    a_esc_pair: assert property (
        api_framing_select == 2'h2 && tx_valid && tx_ready
        && tx_data == 8'h7d
        |=> tx_valid && tx_data inside {8'h5e, 8'h5d, 8'h31, 8'h33})
        else $error("bad escaped byte");
    a_esc_set: assert property (
        api_framing_select == 2'h2 && tx_valid
        |-> !(tx_data inside {8'h11, 8'h13}))
        else $error("flow byte unescaped");
    a_transp_quiet: assert property (
        api_framing_select == 2'h0 |-> !req_ready && !stat_valid
        && !stat_error)
        else $error("frame activity in transparent mode");
    a_one_frame: assert property (
        req_valid && req_ready |=> ##1 !req_ready [*6])
        else $error("request taken mid frame");
    a_hold_byte: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped before accept");
    a_stat_cause: assert property (
        stat_valid |-> $past(rx_valid))
        else $error("status without checksum byte");
    a_err_cause: assert property (
        stat_error |-> $past(rx_valid) && !stat_valid)
        else $error("error without checksum byte");
    a_stat_pulse: assert property (
        stat_valid |=> !stat_valid)
        else $error("status pulse too long");
    c_stat: cover property (stat_valid);
    c_err: cover property (stat_error);
    c_esc: cover property (api_framing_select == 2'h2 && tx_valid
        && tx_ready && tx_data == 8'h7d);
endmodule : afx_host_assertions

bind afx_host afx_host_assertions u_chk (.clock, .rst,
    .api_framing_select, .req_valid, .req_ready, .tx_valid, .tx_ready,
    .tx_data, .rx_valid, .stat_valid, .stat_error);

// ===== tb/afx_dev_model.sv
`timescale 1ns/1ns
module afx_dev_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic       slow,
    input  wire logic       bad,
    input  wire logic       junk,
    input  wire logic [7:0] st,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    logic [7:0] f [0:63];
    logic [7:0] q [$];
    int         n, last, frames, esc_n;
    logic       esc;
    ////////////////////////////////////////////////////////////
    function automatic void push(input logic [7:0] v);
        if (mode == 2'h2 && v inside {8'h7e, 8'h7d, 8'h11, 8'h13}) begin
            q.push_back(8'h7d);
            q.push_back(v ^ 8'h20);
        end else
            q.push_back(v);
    endfunction : push

    function automatic void reply(input logic [7:0] id);
        logic [7:0] c;
        c = 8'hff - (8'h89 + id + st);
        if (bad)
            c = ~c;
        // Truncated frame first: receiver must restart on next delimiter
        if (junk) begin
            q.push_back(8'h7e);
            q.push_back(8'h00);
        end
        q.push_back(8'h7e);
        push(8'h00);
        push(8'h03);
        push(8'h89);
        push(id);
        push(st);
        push(c);
    endfunction : reply

    function automatic void take(input logic [7:0] v);
        logic [7:0] s;
        if (n == 0)
            return;
        f[n] = v;
        n++;
        if (n > 3 && n == {f[1], f[2]} + 4) begin
            s = 8'h00;
            for (int i = 3; i < n; i++)
                s += f[i];
            frames++;
            last = n;
            n = 0;
            if (s == 8'hff && f[3] == 8'h00 && f[4] != 8'h00)
                reply(f[4]);
        end
    endfunction : take
    ////////////////////////////////////////////////////////////
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            n = 0;
            last = 0;
            frames = 0;
            esc_n = 0;
            esc = 1'b0;
            q.delete();
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            // Stalling every other cycle when slow
            tx_ready <= #1 slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                if (mode == 2'h0) begin
                    f[n] = tx_data;
                    n++;
                end else if (esc) begin
                    esc = 1'b0;
                    take(tx_data ^ 8'h20);
                end else if (mode == 2'h2 && tx_data == 8'h7d) begin
                    esc = 1'b1;
                    esc_n++;
                end else if (tx_data == 8'h7e && (mode == 2'h2 || n == 0)) begin
                    n = 1;
                    esc_n = 0;
                    f[0] = tx_data;
                end else
                    take(tx_data);
            end
            if (q.size() != 0) begin
                rx_valid <= #1 1'b1;
                rx_data <= #1 q.pop_front();
            end else begin
                // Idle line drops valid and inverts the data byte every cycle
                rx_valid <= #1 1'b0;
                rx_data <= #1 ~rx_data;
            end
        end
    end
endmodule : afx_dev_model

// ===== tb/afx_host_tb.sv
`timescale 1ns/1ns
module afx_host_tb;
    logic            clock, rst, req_valid, req_broadcast, pay_valid;
    logic            slow, bad, junk;
    logic [1:0]      mode;
    logic [7:0]      req_frame_id, req_options, pay_data, st;
    logic [7:0]      p [0:15];
    logic [7:0]      e [0:31];
    logic [63:0]     req_dest;
    logic [15:0]     req_pay_len;
    wire logic       req_ready, pay_ready, tx_valid, tx_ready, rx_valid;
    wire logic       stat_valid, stat_error;
    wire logic [7:0] tx_data, rx_data, stat_frame_id, stat_delivery;
    int              bad_count = 0, n_checks = 0, sv_n = 0, se_n = 0;
    int              ne, s0, e0;
    ////////////////////////////////////////////////////////////
    afx_host #(.FIFO_DEPTH(16)) dut (.clock, .rst,
        .api_framing_select(mode), .req_valid, .req_ready, .req_frame_id,
        .req_dest, .req_broadcast, .req_options, .req_pay_len, .pay_valid,
        .pay_ready, .pay_data, .tx_valid, .tx_ready, .tx_data, .rx_valid,
        .rx_data, .stat_valid, .stat_frame_id, .stat_delivery, .stat_error);
    afx_dev_model dev (.clock, .rst, .mode, .slow, .bad, .junk, .st,
        .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        if (stat_valid === 1'b1)
            sv_n++;
        if (stat_error === 1'b1)
            se_n++;
    end
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [15:0] ex,
                       input logic [15:0] got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", nm, ex, got);
        end
    endtask : chk

    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick

    task automatic restart(input logic [1:0] m);
        rst = 1'b1;
        mode = m;
        repeat (2) tick();
        rst = 1'b0;
        tick();
    endtask : restart

    task automatic load(input int np);
        int k;
        for (int i = 0; i < np; i++) begin
            pay_valid = 1'b1;
            pay_data = p[i];
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (pay_ready !== 1'b1 && k < 500);
            #1;
        end
        pay_valid = 1'b0;
    endtask : load

    // Waits for the reply bytes to drain, then a fixed three cycles for the status pulse
    task automatic settle;
        int k;
        k = 0;
        while (dev.q.size() != 0 && k < 200) begin
            tick();
            k++;
        end
        repeat (3) tick();
    endtask : settle

    task automatic send(input logic [7:0] id, input logic [63:0] d,
                        input logic bc, input logic [7:0] op, input int np);
        logic [7:0]  s;
        logic [63:0] dd;
        int          k, f0, x;
        f0 = dev.frames;
        s0 = sv_n;
        e0 = se_n;
        load(np);
        if (np == 16) begin
            tick();
            chk("fifo ready", 16'h0, 16'(pay_ready));
        end
        req_frame_id = id;
        req_dest = d;
        req_broadcast = bc;
        req_options = op;
        req_pay_len = 16'(np);
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (req_ready !== 1'b1 && k < 500);
        #1 req_valid = 1'b0;
        k = 0;
        while (dev.frames == f0 && k < 2000) begin
            tick();
            k++;
        end
        dd = bc ? 64'h0000_0000_0000_ffff : d;
        e[0] = 8'h7e;
        {e[1], e[2]} = 16'(11 + np);
        e[3] = 8'h00;
        e[4] = id;
        for (int i = 0; i < 8; i++)
            e[5 + i] = dd[63 - 8 * i -: 8];
        e[13] = op & 8'h05;
        for (int i = 0; i < np; i++)
            e[14 + i] = p[i];
        s = 8'hff;
        for (int i = 3; i < 14 + np; i++)
            s -= e[i];
        e[14 + np] = s;
        ne = 15 + np;
        x = 0;
        for (int i = 1; i < ne; i++)
            if (e[i] inside {8'h7e, 8'h7d, 8'h11, 8'h13})
                x++;
        chk("frame length", 16'(ne), 16'(dev.last));
        for (int i = 0; i < ne; i++)
            chk("frame byte", 16'(e[i]), 16'(dev.f[i]));
        chk("escapes", 16'(mode == 2'h2 ? x : 0), 16'(dev.esc_n));
    endtask : send
    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        mode = 2'h1;
        {req_valid, req_broadcast, pay_valid, slow, bad, junk} = '0;
        {req_frame_id, req_options, pay_data, st} = '0;
        req_dest = '0;
        req_pay_len = '0;
        repeat (6) tick();
        rst = 1'b0;
        tick();
        // Framed unicast with every option bit raised
        for (int i = 0; i < 6; i++)
            p[i] = 8'h40 + 8'(i);
        send(8'h52, 64'h0102_0304_0506_0708, 1'b0, 8'hff, 6);
        settle();
        chk("status count", 16'h1, 16'(sv_n - s0));
        chk("status id", 16'h52, 16'(stat_frame_id));
        chk("status code", 16'h0, 16'(stat_delivery));
        // Escaped mode, slow device, special bytes everywhere
        restart(2'h2);
        {slow, junk} = 2'b11;
        st = 8'h02;
        p[0:5] = '{8'h7e, 8'h7d, 8'h11, 8'h13, 8'h20, 8'h5e};
        send(8'h7d, 64'h1113_7d7e_0000_0000, 1'b0, 8'h01, 6);
        settle();
        chk("escaped status id", 16'h7d, 16'(stat_frame_id));
        chk("escaped status code", 16'h2, 16'(stat_delivery));
        // Full buffer, broadcast, no response wanted
        restart(2'h1);
        junk = 1'b0;
        for (int i = 0; i < 16; i++)
            p[i] = 8'h80 + 8'(i);
        send(8'h00, 64'h0, 1'b1, 8'h04, 16);
        settle();
        chk("silent id zero", 16'h0, 16'(sv_n - s0));
        // Corrupted status checksum is dropped
        bad = 1'b1;
        send(8'h21, 64'hffff_0000_0000_0001, 1'b0, 8'h05, 1);
        settle();
        chk("bad sum error", 16'h1, 16'(se_n - e0));
        chk("bad sum status", 16'h0, 16'(sv_n - s0));
        // Transparent mode passes bytes raw, refuses requests
        restart(2'h0);
        {slow, bad} = 2'b00;
        req_valid = 1'b1;
        p[0:2] = '{8'h7e, 8'h7d, 8'h11};
        load(3);
        repeat (10) tick();
        chk("raw count", 16'h3, 16'(dev.n));
        for (int i = 0; i < 3; i++)
            chk("raw byte", 16'(p[i]), 16'(dev.f[i]));
        chk("transparent ready", 16'h0, 16'(req_ready));
        req_valid = 1'b0;
        report_and_stop();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule : afx_host_tb
